// ---- src/cacfg_top.sv ----
`timescale 1ns/1ps
`include "cacfg_defs.svh"
// configuration and mode control of the six channel counter array

// Notes on behaviour
// - bank bit picks value or reload registers
// - reload used only in 9-11 bit pwm
// - overflow enable gates overflow interrupt
// - overflow flag from selected counter bit
// - hardware or software sets, software clears
// - cycle config bits 4:2 read zero
// - length codes 00/01/10 give 8/9/10 bits
// - length ignored by 16-bit pwm channels
// - wide bit selects 16-bit pwm
// - comparator enable gates compare
// - rising edge capture enable
// - falling edge capture enable
// - match sets channel flag
// - toggle inverts pin on match
// - toggle plus pwm means frequency output
// - pwm enable drives pwm waveform
// - channel flag interrupt enable
// - watchdog locks channel five mode writes, value byte writes still change its comparator enable
// - low value write clears comparator enable
// - high counter byte read is snapshot
module cacfg_top #(
   parameter int NCH = 6
) (
   // clock, reset, enable
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic CE,
   // special function register bus
   input wire logic [7:0] SFR_ADDR,
   input wire logic SFR_WR,
   input wire logic SFR_RD,
   input wire logic [7:0] SFR_WDATA,
   output logic [7:0] SFR_RDATA,
   output logic SFR_HIT,
   // counter and watchdog from the rest of the array
   input wire logic CNT_TICK,
   input wire logic WATCHDOG_ENABLE,
   // channel pins
   input wire logic [5:0] CHANNEL_PIN_IN,
   output logic [5:0] CHANNEL_PIN,
   // interrupt request and flags
   output logic IRQ,
   output logic [5:0] CAPTURE_COMPARE_FLAG
);
   cacfg_pkg::cacfg_byte_t cfg_ff, nxt_cfg;
   cacfg_pkg::cacfg_byte_t mode_ff [NCH];
   cacfg_pkg::cacfg_byte_t nxt_mode [NCH];
   logic [15:0] val_ff [NCH];
   logic [15:0] nxt_val [NCH];
   logic [15:0] rld_ff [NCH];
   logic [15:0] nxt_rld [NCH];
   logic [NCH-1:0] flag_ff, nxt_flag;
   logic [15:0] cnt_ff, nxt_cnt;
   logic [7:0] snap_ff, nxt_snap;
   logic [1:0] wd_sync_ff;
   logic wd_en;
   logic [NCH-1:0] rise, fall, cap_hit, match_hit, load_rl, pin_o;
   logic cycle_wrap;
   logic [16:0] cnt_inc;
   logic [7:0] rdata;
   logic hit;

   // channel address decode, -1 when none
   function automatic int lo_idx(input logic [7:0] a);
      case (a)
         `CA_ADDR_VAL_LO0: lo_idx = 0;
         `CA_ADDR_VAL_LO1: lo_idx = 1;
         `CA_ADDR_VAL_LO2: lo_idx = 2;
         `CA_ADDR_VAL_LO3: lo_idx = 3;
         `CA_ADDR_VAL_LO4: lo_idx = 4;
         `CA_ADDR_VAL_LO5: lo_idx = 5;
         default: lo_idx = -1;
      endcase
   endfunction : lo_idx

   function automatic int hi_idx(input logic [7:0] a);
      case (a)
         `CA_ADDR_VAL_HI0: hi_idx = 0;
         `CA_ADDR_VAL_HI1: hi_idx = 1;
         `CA_ADDR_VAL_HI2: hi_idx = 2;
         `CA_ADDR_VAL_HI3: hi_idx = 3;
         `CA_ADDR_VAL_HI4: hi_idx = 4;
         `CA_ADDR_VAL_HI5: hi_idx = 5;
         default: hi_idx = -1;
      endcase
   endfunction : hi_idx

   function automatic int md_idx(input logic [7:0] a);
      case (a)
         `CA_ADDR_CH0_MODE: md_idx = 0;
         `CA_ADDR_CH1_MODE: md_idx = 1;
         `CA_ADDR_CH2_MODE: md_idx = 2;
         `CA_ADDR_CH3_MODE: md_idx = 3;
         `CA_ADDR_CH4_MODE: md_idx = 4;
         `CA_ADDR_CH5_MODE: md_idx = 5;
         default: md_idx = -1;
      endcase
   endfunction : md_idx

   // watchdog enable comes from another block, so it is synchronised
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N)
         wd_sync_ff <= 2'b00;
      else if (CE)
         wd_sync_ff <= {wd_sync_ff[0], WATCHDOG_ENABLE};
   end
   assign wd_en = wd_sync_ff[1];

   // per channel edge detect and mode logic
   for (genvar i = 0; i < NCH; i++) begin : g_ch
      cacfg_edge u_edge (
         .clk(CLK),
         .rst_n(RST_N),
         .ce(CE),
         .pin_in(CHANNEL_PIN_IN[i]),
         .rise(rise[i]),
         .fall(fall[i])
      );
      cacfg_chan u_chan (
         .clk(CLK),
         .rst_n(RST_N),
         .ce(CE),
         .mode(mode_ff[i]),
         .len_sel(cfg_ff[1:0]),
         .cmp_val(val_ff[i]),
         .reload_val(rld_ff[i]),
         .count(cnt_ff),
         .cycle_wrap(cycle_wrap),
         .rise(rise[i]),
         .fall(fall[i]),
         .cap_hit(cap_hit[i]),
         .match_hit(match_hit[i]),
         .load_reload(load_rl[i]),
         .pin_out(pin_o[i])
      );
   end

   // counter increment and cycle overflow detect
   assign cnt_inc = {1'b0, cnt_ff} + 17'd1;
   always_comb begin
      // overflow bit chosen by length select
      case (cacfg_pkg::cacfg_len_e'(cfg_ff[1:0]))
         cacfg_pkg::CACFG_LEN8: cycle_wrap = CNT_TICK & (&cnt_ff[7:0]);
         cacfg_pkg::CACFG_LEN9: cycle_wrap = CNT_TICK & (&cnt_ff[8:0]);
         cacfg_pkg::CACFG_LEN10: cycle_wrap = CNT_TICK & (&cnt_ff[9:0]);
         default: cycle_wrap = CNT_TICK & (&cnt_ff[10:0]);
      endcase
   end

   // register file next state
   always_comb begin
      int li, hj, mk;
      li = lo_idx(SFR_ADDR);
      hj = hi_idx(SFR_ADDR);
      mk = md_idx(SFR_ADDR);
      nxt_cfg = cfg_ff;
      nxt_mode = mode_ff;
      nxt_val = val_ff;
      nxt_rld = rld_ff;
      nxt_flag = flag_ff;
      nxt_cnt = CNT_TICK ? cnt_inc[15:0] : cnt_ff;
      nxt_snap = snap_ff;
      // software writes first, hardware sets after so sets win
      if (SFR_WR) begin
         if (SFR_ADDR == `CA_ADDR_CYCLE_CFG)
            nxt_cfg = SFR_WDATA & `CA_CFG_WMASK;
         if (mk >= 0 && !(mk == `CA_WDOG_CHANNEL && wd_en))
            nxt_mode[mk] = SFR_WDATA;
         if (!wd_en && SFR_ADDR == `CA_ADDR_CNT_LO)
            nxt_cnt[7:0] = SFR_WDATA;
         if (!wd_en && SFR_ADDR == `CA_ADDR_CNT_HI)
            nxt_cnt[15:8] = SFR_WDATA;
         if (li >= 0) begin
            if (cfg_ff[`CA_CFG_BANK_BIT])
               nxt_rld[li][7:0] = SFR_WDATA;
            else begin
               nxt_val[li][7:0] = SFR_WDATA;
               nxt_mode[li][`CA_MD_CMP_BIT] = 1'b0;
            end
         end
         if (hj >= 0) begin
            if (cfg_ff[`CA_CFG_BANK_BIT])
               nxt_rld[hj][15:8] = SFR_WDATA;
            else begin
               nxt_val[hj][15:8] = SFR_WDATA;
               nxt_mode[hj][`CA_MD_CMP_BIT] = 1'b1;
            end
         end
      end
      // snapshot taken on low byte read
      if (SFR_RD && SFR_ADDR == `CA_ADDR_CNT_LO)
         nxt_snap = cnt_ff[15:8];
      // hardware only sets the overflow flag
      if (cycle_wrap)
         nxt_cfg[`CA_CFG_CYCLE_OVERFLOW_FLAG_BIT] = 1'b1;
      for (int i = 0; i < NCH; i++) begin
         if (cap_hit[i]) begin
            nxt_val[i] = cnt_ff;
            nxt_flag[i] = 1'b1;
         end
         if (match_hit[i])
            nxt_flag[i] = 1'b1;
         if (load_rl[i])
            nxt_val[i] = rld_ff[i];
      end
   end

   // register file state
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         cfg_ff <= `CA_RESET_BYTE;
         flag_ff <= '0;
         cnt_ff <= 16'h0000;
         snap_ff <= `CA_RESET_BYTE;
         for (int i = 0; i < NCH; i++) begin
            mode_ff[i] <= `CA_RESET_BYTE;
            val_ff[i] <= 16'h0000;
            rld_ff[i] <= 16'h0000;
         end
      end else if (CE) begin
         cfg_ff <= nxt_cfg;
         flag_ff <= nxt_flag;
         cnt_ff <= nxt_cnt;
         snap_ff <= nxt_snap;
         mode_ff <= nxt_mode;
         val_ff <= nxt_val;
         rld_ff <= nxt_rld;
      end
   end

   // read mux, unmapped addresses return zero and no hit
   always_comb begin
      int li, hj, mk;
      li = lo_idx(SFR_ADDR);
      hj = hi_idx(SFR_ADDR);
      mk = md_idx(SFR_ADDR);
      rdata = 8'h00;
      hit = 1'b1;
      if (SFR_ADDR == `CA_ADDR_CYCLE_CFG)
         rdata = cfg_ff & `CA_CFG_WMASK;
      else if (mk >= 0)
         rdata = mode_ff[mk];
      else if (SFR_ADDR == `CA_ADDR_CNT_LO)
         rdata = cnt_ff[7:0];
      else if (SFR_ADDR == `CA_ADDR_CNT_HI)
         rdata = snap_ff;
      else if (li >= 0)
         rdata = cfg_ff[`CA_CFG_BANK_BIT] ? rld_ff[li][7:0]
                                          : val_ff[li][7:0];
      else if (hj >= 0)
         rdata = cfg_ff[`CA_CFG_BANK_BIT] ? rld_ff[hj][15:8]
                                          : val_ff[hj][15:8];
      else
         hit = 1'b0;
   end

   assign SFR_RDATA = rdata;
   assign SFR_HIT = hit;
   assign CHANNEL_PIN = pin_o;
   assign CAPTURE_COMPARE_FLAG = flag_ff;

   // interrupt request from enabled flags
   always_comb begin
      IRQ = cfg_ff[`CA_CFG_COVIE_BIT] & cfg_ff[`CA_CFG_CYCLE_OVERFLOW_FLAG_BIT];
      for (int i = 0; i < NCH; i++)
         IRQ = IRQ | (mode_ff[i][`CA_MD_IRQ_BIT] & flag_ff[i]);
   end
endmodule : cacfg_top

// ---- shared/cacfg_defs.svh ----
// offsets, field positions, reset value and watchdog channel of the counter array
`ifndef CACFG_DEFS_SVH
`define CACFG_DEFS_SVH
`define CA_ADDR_CH0_MODE 8'h00_DA
`define CA_ADDR_CH1_MODE 8'h00_DB
`define CA_ADDR_CH2_MODE 8'h00_DC
`define CA_ADDR_CH3_MODE 8'h00_DD
`define CA_ADDR_CH4_MODE 8'h00_DE
`define CA_ADDR_CH5_MODE 8'h00_CE
`define CA_ADDR_CYCLE_CFG 8'h00_DF
`define CA_ADDR_CNT_LO 8'h00_F9
`define CA_ADDR_CNT_HI 8'h00_FA
`define CA_ADDR_VAL_LO0 8'h00_FB
`define CA_ADDR_VAL_HI0 8'h00_FC
`define CA_ADDR_VAL_LO1 8'h00_E9
`define CA_ADDR_VAL_HI1 8'h00_EA
`define CA_ADDR_VAL_LO2 8'h00_EB
`define CA_ADDR_VAL_HI2 8'h00_EC
`define CA_ADDR_VAL_LO3 8'h00_ED
`define CA_ADDR_VAL_HI3 8'h00_EE
`define CA_ADDR_VAL_LO4 8'h00_FD
`define CA_ADDR_VAL_HI4 8'h00_FE
`define CA_ADDR_VAL_LO5 8'h00_D2
`define CA_ADDR_VAL_HI5 8'h00_D3
// cycle configuration fields
`define CA_CFG_BANK_BIT 7
`define CA_CFG_COVIE_BIT 6
`define CA_CFG_CYCLE_OVERFLOW_FLAG_BIT 5
`define CA_CFG_WMASK 8'h00_E3
// channel mode fields
`define CA_MD_WIDE_BIT 7
`define CA_MD_CMP_BIT 6
`define CA_MD_CAPR_BIT 5
`define CA_MD_CAPF_BIT 4
`define CA_MD_MATCH_BIT 3
`define CA_MD_TOG_BIT 2
`define CA_MD_PWM_BIT 1
`define CA_MD_IRQ_BIT 0
`define CA_RESET_BYTE 8'h00_00
`define CA_WDOG_CHANNEL 5
`endif

// ---- shared/cacfg_pkg.sv ----
// types shared by the counter array configuration block
package cacfg_pkg;
   typedef enum logic [1:0] {
      CACFG_LEN8 = 2'b00,
      CACFG_LEN9 = 2'b01,
      CACFG_LEN10 = 2'b10,
      CACFG_LEN11 = 2'b11
   } cacfg_len_e;
   typedef enum logic [2:0] {
      CACFG_OFF = 3'b000,
      CACFG_CAPTURE = 3'b001,
      CACFG_TOGGLE = 3'b010,
      CACFG_FREQ = 3'b011,
      CACFG_PWM_N = 3'b100,
      CACFG_PWM16 = 3'b101
   } cacfg_mode_e;
   typedef logic [7:0] cacfg_byte_t;
endpackage : cacfg_pkg

// ---- src/cacfg_edge.sv ----
`timescale 1ns/1ps
// pin synchroniser and edge detector for one channel input
module cacfg_edge (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // pin and edges
   input wire logic pin_in,
   output logic rise,
   output logic fall
);
   logic s1_ff, s2_ff, s3_ff;
   logic nxt_s1, nxt_s2, nxt_s3;

   // the second and third stages are seen by the edge logic
   always_comb begin
      nxt_s1 = pin_in;
      nxt_s2 = s1_ff;
      nxt_s3 = s2_ff;
   end

   // state registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_ff <= 1'b0;
         s2_ff <= 1'b0;
         s3_ff <= 1'b0;
      end else if (ce) begin
         s1_ff <= nxt_s1;
         s2_ff <= nxt_s2;
         s3_ff <= nxt_s3;
      end
   end

   // edge pulses, one cycle each
   assign rise = ce & s2_ff & ~s3_ff;
   assign fall = ce & ~s2_ff & s3_ff;
endmodule : cacfg_edge

// ---- src/cacfg_chan.sv ----
`timescale 1ns/1ps
`include "cacfg_defs.svh"
// one channel: compare, capture, toggle, pwm and frequency output
module cacfg_chan (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // configuration
   input wire logic [7:0] mode,
   input wire logic [1:0] len_sel,
   input wire logic [15:0] cmp_val,
   input wire logic [15:0] reload_val,
   input wire logic [15:0] count,
   input wire logic cycle_wrap,
   input wire logic rise,
   input wire logic fall,
   // results
   output logic cap_hit,
   output logic match_hit,
   output logic load_reload,
   output logic pin_out
);
   logic pin_ff, nxt_pin;
   logic [15:0] mask;
   logic eq;
   cacfg_pkg::cacfg_mode_e md;

   // compare width follows the cycle length whenever pwm is set and wide is clear (8 to 11-bit pwm or frequency output), otherwise 16 bits
   always_comb begin
      case (cacfg_pkg::cacfg_len_e'(len_sel))
         cacfg_pkg::CACFG_LEN8: mask = 16'h00FF;
         cacfg_pkg::CACFG_LEN9: mask = 16'h01FF;
         cacfg_pkg::CACFG_LEN10: mask = 16'h03FF;
         default: mask = 16'h07FF;
      endcase
      if (mode[`CA_MD_WIDE_BIT] || !mode[`CA_MD_PWM_BIT])
         mask = 16'hFFFF;
   end

   assign eq = mode[`CA_MD_CMP_BIT] && ((count & mask) == (cmp_val & mask));

   // decode operating mode
   always_comb begin
      if (mode[`CA_MD_TOG_BIT] && mode[`CA_MD_PWM_BIT])
         md = cacfg_pkg::CACFG_FREQ;
      else if (mode[`CA_MD_PWM_BIT] && mode[`CA_MD_WIDE_BIT])
         md = cacfg_pkg::CACFG_PWM16;
      else if (mode[`CA_MD_PWM_BIT])
         md = cacfg_pkg::CACFG_PWM_N;
      else if (mode[`CA_MD_TOG_BIT])
         md = cacfg_pkg::CACFG_TOGGLE;
      else
         md = cacfg_pkg::CACFG_OFF;
   end

   assign cap_hit = (mode[`CA_MD_CAPR_BIT] & rise) |
                    (mode[`CA_MD_CAPF_BIT] & fall);
   assign match_hit = ce & eq & mode[`CA_MD_MATCH_BIT];
   // reload only in 9 to 11-bit pwm
   assign load_reload = ce & cycle_wrap &
      (md == cacfg_pkg::CACFG_PWM_N) &
      (len_sel != 2'(cacfg_pkg::CACFG_LEN8));

   // output pin level
   always_comb begin
      nxt_pin = pin_ff;
      case (md)
         cacfg_pkg::CACFG_TOGGLE, cacfg_pkg::CACFG_FREQ: begin
            if (eq)
               nxt_pin = ~pin_ff;
         end
         // pwm: low on match, high on wrap
         cacfg_pkg::CACFG_PWM_N, cacfg_pkg::CACFG_PWM16: begin
            if (eq)
               nxt_pin = 1'b0;
            else if ((count & mask) == 16'h0000)
               nxt_pin = 1'b1;
         end
         default: nxt_pin = pin_ff;
      endcase
   end

   // pin register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         pin_ff <= 1'b0;
      else if (ce)
         pin_ff <= nxt_pin;
   end

   assign pin_out = pin_ff;
   // reload value is consumed by the top on load_reload
   logic unused_rl;
   assign unused_rl = ^reload_val;
endmodule : cacfg_chan

// ---- dv/cacfg_top_sva.sv ----
`timescale 1ns/1ps
// port assertions for the counter array configuration block
module cacfg_top_sva #(
   parameter int NCH = 6
) (
   // clock, reset, enable
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic CE,
   // register bus
   input wire logic [7:0] SFR_ADDR,
   input wire logic SFR_WR,
   input wire logic SFR_RD,
   input wire logic [7:0] SFR_WDATA,
   input wire logic [7:0] SFR_RDATA,
   input wire logic SFR_HIT,
   // counter, watchdog, pins, interrupt
   input wire logic CNT_TICK,
   input wire logic WATCHDOG_ENABLE,
   input wire logic [5:0] CHANNEL_PIN_IN,
   input wire logic [5:0] CHANNEL_PIN,
   input wire logic IRQ,
   input wire logic [5:0] CAPTURE_COMPARE_FLAG
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_N);

   // accepted writes; the watchdog needs time to cross its synchroniser
   sequence s_cfg_wr;
      CE && SFR_WR && SFR_ADDR == 8'hDF;
   endsequence
   sequence s_locked_wr;
      WATCHDOG_ENABLE [*4] ##0 CE && SFR_WR && SFR_ADDR == 8'hCE;
   endsequence

   a_unused_read_zero: assert property (
      SFR_ADDR == 8'hDF |-> SFR_RDATA[4:2] == 3'b000)
      else $error("cycle config unused bits not zero");
   a_cfg_write_lands: assert property (
      s_cfg_wr ##1 SFR_ADDR == 8'hDF |->
      (SFR_RDATA & 8'hC3) == ($past(SFR_WDATA) & 8'hC3))
      else $error("cycle config write lost");
   a_ovf_flag_sticky: assert property (
      SFR_ADDR == 8'hDF && SFR_RDATA[5] && !SFR_WR ##1
      SFR_ADDR == 8'hDF |-> SFR_RDATA[5])
      else $error("overflow flag cleared without a write");
   a_irq_overflow: assert property (
      SFR_ADDR == 8'hDF && SFR_RDATA[6] && SFR_RDATA[5] |-> IRQ)
      else $error("enabled overflow flag gives no interrupt");
   a_irq_channel: assert property (
      SFR_ADDR == 8'hDA && SFR_RDATA[0] && CAPTURE_COMPARE_FLAG[0] |-> IRQ)
      else $error("enabled channel flag gives no interrupt");
   a_flag_stands: assert property (
      1'b1 |=> ($past(CAPTURE_COMPARE_FLAG) & ~CAPTURE_COMPARE_FLAG) == 6'h00)
      else $error("channel flag dropped");
   a_wdog_mode_lock: assert property (
      s_locked_wr ##1 SFR_ADDR == 8'hCE |-> $stable(SFR_RDATA))
      else $error("channel five mode changed under watchdog");
   // unmapped space reads as zero
   a_unmapped_zero: assert property (
      !SFR_HIT |-> SFR_RDATA == 8'h00)
      else $error("unmapped address returned data");
   // mode and config addresses are mapped
   a_mapped_hit: assert property (
      SFR_ADDR inside {8'hCE, [8'hDA:8'hDF]} |-> SFR_HIT)
      else $error("mapped address not decoded");
endmodule : cacfg_top_sva

bind cacfg_top cacfg_top_sva #(.NCH(NCH)) u_sva (
   .CLK, .RST_N, .CE, .SFR_ADDR, .SFR_WR, .SFR_RD, .SFR_WDATA, .SFR_RDATA,
   .SFR_HIT, .CNT_TICK, .WATCHDOG_ENABLE, .CHANNEL_PIN_IN, .CHANNEL_PIN,
   .IRQ, .CAPTURE_COMPARE_FLAG
);

// ---- dv/cacfg_top_bench.sv ----
`timescale 1ns/1ps
// self-checking bench for the counter array configuration block
module cacfg_top_bench;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   logic [7:0] addr = 8'h00;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic [7:0] wdata = 8'h00;
   logic tick = 1'b0;
   logic wdog = 1'b0;
   logic [5:0] pin_in = 6'h00;
   logic chk_en = 1'b0;
   logic [1:0] chk_sel = 2'd0;
   logic [7:0] rdata;
   logic [5:0] pin;
   logic [5:0] flag;
   logic irq;
   logic [7:0] exp_q[$];
   logic [7:0] r;
   logic [7:0] regs [8] = '{8'hDA, 8'hDB, 8'hDC, 8'hDD, 8'hDE, 8'hCE,
      8'hDF, 8'h00};
   int n_errors = 0;
   int compares = 0;
   integer seed = 32'h928e_9ac7;

   // 250 MHz system clock
   always #2 clk = ~clk;

   cacfg_top u_dut (
      .CLK(clk), .RST_N(rst_n), .CE(ce), .SFR_ADDR(addr), .SFR_WR(wr_en),
      .SFR_RD(rd_en), .SFR_WDATA(wdata), .SFR_RDATA(rdata), .SFR_HIT(),
      .CNT_TICK(tick), .WATCHDOG_ENABLE(wdog), .CHANNEL_PIN_IN(pin_in),
      .CHANNEL_PIN(pin), .IRQ(irq), .CAPTURE_COMPARE_FLAG(flag)
   );

   task automatic check(input logic [7:0] seen, input logic [7:0] e);
      compares++;
      if (seen !== e) begin
         $display("Error at %0t: seen %h expected %h", $time, seen, e);
         n_errors++;
      end
   endtask : check

   task automatic end_of_test();
      $display("compares %0d errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_of_test

   // inputs move 1 ns after the edge, clear of sampling
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step

   // idle cycle after each strobe so it is never re-raised in one step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      addr = a;
      wdata = d;
      wr_en = 1'b1;
      step(1);
      wr_en = 1'b0;
      step(1);
   endtask : wr

   task automatic look(input logic [1:0] s, input logic [7:0] e);
      exp_q.push_back(e);
      chk_sel = s;
      chk_en = 1'b1;
      step(1);
      chk_en = 1'b0;
      rd_en = 1'b0;
      step(1);
   endtask : look

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      addr = a;
      rd_en = 1'b1;
      look(2'd0, e);
   endtask : rd

   // counter high byte first, so the low write lands last
   task automatic cnt(input logic [15:0] v);
      wr(8'hFA, v[15:8]);
      wr(8'hF9, v[7:0]);
   endtask : cnt

   task automatic ticks(input int n);
      tick = 1'b1;
      step(n);
      tick = 1'b0;
      step(1);
   endtask : ticks

   // oldest expectation against whatever was observed at this edge
   always @(posedge clk) begin
      if (chk_en) begin
         case (chk_sel)
            2'd0: check(rdata, exp_q.pop_front());
            2'd1: check({2'b00, flag}, exp_q.pop_front());
            2'd2: check({7'h00, irq}, exp_q.pop_front());
            default: check({2'b00, pin}, exp_q.pop_front());
         endcase
      end
   end

   // hang guard, well beyond the expected run
   initial begin
      repeat (5000) @(posedge clk);
      n_errors++;
      end_of_test();
   end

   initial begin
      step(12);
      rst_n = 1'b1;
      step(1);
      foreach (regs[i]) rd(regs[i], 8'h00);
      // random config and mode writes; compare and pin drive kept off
      repeat (4) begin
         r = $random(seed);
         wr(8'hDF, r);
         rd(8'hDF, r & 8'hE3);
      end
      for (int c = 0; c < 5; c++) begin
         r = $random(seed) & 8'hB9;
         wr(8'hDA + 8'(c), r);
         rd(8'hDA + 8'(c), r);
         wr(8'hDA + 8'(c), 8'h00);
      end
      $display("test registers done");
      // overflow at every cycle length, enabled then masked
      for (int l = 0; l < 4; l++) begin
         wr(8'hDF, 8'h40 | 8'(l));
         cnt((16'h0001 << (8 + l)) - 16'h0002);
         ticks(1);
         rd(8'hDF, 8'h40 | 8'(l));
         ticks(1);
         rd(8'hDF, 8'h60 | 8'(l));
         look(2'd2, 8'h01);
         rd(8'hF9, 8'h00);
         rd(8'hFA, 8'h01 << l);
         wr(8'hDF, 8'h20 | 8'(l));
         look(2'd2, 8'h00);
         wr(8'hDF, 8'h00);
         rd(8'hDF, 8'h00);
      end
      $display("test overflow done");
      // capture with the counter held still
      cnt(16'h1234);
      wr(8'hDA, 8'h21);
      wr(8'hDB, 8'h10);
      pin_in = 6'h06;
      step(5);
      look(2'd1, 8'h00);
      pin_in = 6'h01;
      step(5);
      look(2'd1, 8'h03);
      rd(8'hFB, 8'h34);
      rd(8'hEA, 8'h12);
      rd(8'hDA, 8'h21);
      look(2'd2, 8'h01);
      wr(8'hDA, 8'h20);
      look(2'd2, 8'h00);
      // reload bank hides the captured value
      wr(8'hDF, 8'h80);
      wr(8'hFB, 8'hA5);
      rd(8'hFB, 8'hA5);
      wr(8'hDF, 8'h00);
      rd(8'hFB, 8'h34);
      $display("test capture done");
      // comparator enable follows value byte writes, then match
      wr(8'hDD, 8'h4C);
      wr(8'hED, 8'h10);
      rd(8'hDD, 8'h0C);
      wr(8'hEE, 8'h00);
      rd(8'hDD, 8'h4C);
      cnt(16'h000E);
      ticks(3);
      look(2'd1, 8'h0B);
      look(2'd3, 8'h08);
      // 8-bit pwm: high from wrap, low at match
      wr(8'hFD, 8'h80);
      wr(8'hFE, 8'h80);
      wr(8'hDE, 8'h42);
      cnt(16'h00FF);
      ticks(1);
      look(2'd3, 8'h18);
      ticks(128);
      look(2'd3, 8'h08);
      // 9-bit pwm: reload lands in the value at the cycle wrap
      wr(8'hDF, 8'h81);
      wr(8'hEB, 8'h00);
      wr(8'hEC, 8'h01);
      wr(8'hDF, 8'h01);
      wr(8'hDC, 8'h42);
      rd(8'hEC, 8'h00);
      cnt(16'h01FF);
      ticks(1);
      rd(8'hEC, 8'h01);
      $display("test compare done");
      // channel five locked while the watchdog runs
      wdog = 1'b1;
      step(4);
      wr(8'hCE, 8'h5A);
      rd(8'hCE, 8'h00);
      // watchdog off before channel five rewrite
      wdog = 1'b0;
      step(4);
      wr(8'hCE, 8'h11);
      rd(8'hCE, 8'h11);
      $display("test watchdog done");
      step(2);
      end_of_test();
   end
endmodule : cacfg_top_bench
